// file: rtl/opot_chan.sv
// one timer channel: counter, correction, output flip-flop
`timescale 1ns/1ps
module opot_chan (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic tick, // count clock pulse
  input wire logic run, // run bit level
  input wire opot_pkg::opot_mode_t mode, // operating mode
  input wire logic [opot_pkg::CNT_W-1:0] reload, // reload value
  input wire logic [opot_pkg::CNT_W-1:0] corr, // correction value
  input wire logic corr_we, // correction written
  input wire logic ctr_we, // counter written
  input wire logic [opot_pkg::CNT_W-1:0] ctr_wd, // counter write data
  output logic [opot_pkg::CNT_W-1:0] cnt, // counter value
  output logic tout, // output flip-flop
  output logic uflow, // underflow request pulse
  output logic stop // terminating underflow pulse
);
  import opot_pkg::*;

  typedef struct packed {
    opot_state_t st;
    logic [CNT_W-1:0] cnt;
    logic pend;
    logic rl_pend;
    logic tout;
    logic uflow;
    logic stop;
  } opot_chst_t;

  opot_chst_t s_q, s_d;
  logic term;

  always_comb begin
    s_d = s_q;
    term = 1'b0;
    if (ce) begin
      s_d.uflow = 1'b0;
      s_d.stop = 1'b0;
      if (corr_we) begin
        s_d.pend = 1'b1;
      end
      if (tick) begin
        s_d.pend = corr_we;
        if (!run) begin
          s_d.st = ST_IDLE;
          s_d.rl_pend = 1'b0;
        end else begin
          case (s_q.st)
            ST_IDLE: begin
              s_d.st = ST_LEG1;
              s_d.rl_pend = 1'b0;
              if (mode == MODE_SINGLE) begin
                s_d.cnt = reload;
              end
              if (mode == MODE_SINGLE || mode == MODE_CONT) begin
                s_d.tout = ~s_q.tout;
              end
            end
            ST_LEG1, ST_LEG2: begin
              if (s_q.rl_pend) begin
                s_d.cnt = reload - ONE;
                s_d.rl_pend = 1'b0;
              end else if (s_q.pend) begin
                s_d.cnt = s_q.cnt + corr;
              end else if (s_q.cnt == CNT_RST) begin
                s_d.cnt = CNT_ALL_ONES;
                s_d.uflow = 1'b1;
                s_d.tout = ~s_q.tout;
                term = (mode == MODE_SINGLE) || (mode != MODE_CONT && s_q.st == ST_LEG2);
                if (term) begin
                  s_d.st = ST_IDLE;
                  s_d.stop = 1'b1;
                end else begin
                  s_d.rl_pend = 1'b1;
                  s_d.st = (mode == MODE_CONT) ? ST_LEG1 : ST_LEG2;
                end
              end else begin
                s_d.cnt = s_q.cnt - ONE;
              end
            end
            default: begin
              s_d.st = ST_IDLE;
            end
          endcase
        end
      end
      if (ctr_we) begin
        s_d.cnt = ctr_wd;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '{st: ST_IDLE, cnt: CNT_RST, default: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign cnt = s_q.cnt;
  assign tout = s_q.tout;
  assign uflow = s_q.uflow;
  assign stop = s_q.stop;

endmodule

// file: rtl/opot_pkg.sv
// constants and types of the output pulse one-shot timer
// Operation
// - count enable register, one run bit per channel, zero at reset, spare bits read 0
// - outside continuous mode a terminating underflow clears the run bit
// - single-shot start copies reload into counter on a count tick, then decrements
// - single-shot halts at first underflow; pulse spans reload plus one ticks, once
// - single-shot output toggles at start and again at underflow
// - single-shot underflow raises an interrupt request
// - single-shot start ignores whatever the counter held before
// - state machine and output move only on count ticks, so output lags enable by up to one tick period
// - correction value is added to the counter on the tick after the write
// - the tick applying a correction skips the decrement
// - a wrap caused by correction raises nothing and counting goes on
// - the next underflow after such a wrap still raises its request
// - underflow stop beats an external start in the same period
// - software enable beats an underflow stop in the same period
// - software disable beats an external start in the same period
// - delayed mode counts preset down, reloads at first underflow, halts at second
// - delayed mode output toggles at first and second underflow
// - delayed mode raises a request at each of the two underflows
// - write guard register, one bit per channel, 1 blocks run bit rewrites
// - external permit register, one bit per channel, 1 lets the input start it
// - counter reads all ones just after an underflow reload, then reload minus one
package opot_pkg;

  localparam int N_CH = 11;
  localparam int CNT_W = 16;
  localparam int IDX_W = 24;
  localparam int ADDR_W = 26;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] PERMIT_IDX = 24'h80_02fa;
  localparam logic [IDX_W-1:0] GUARD_IDX = 24'h80_02fc;
  localparam logic [IDX_W-1:0] RUN_IDX = 24'h80_02fe;
  localparam logic [IDX_W-1:0] CHAN_BASE_IDX = 24'h80_0240;
  localparam logic [3:0] CHAN_STRIDE_SH = 4'h4;
  localparam logic [3:0] SUB_COUNTER = 4'h0;
  localparam logic [3:0] SUB_RELOAD = 4'h2;
  localparam logic [3:0] SUB_MODE = 4'h4;
  localparam logic [3:0] SUB_CORR = 4'h6;

  localparam logic [CNT_W-1:0] RUN_RST = 16'h0000;
  localparam logic [CNT_W-1:0] GUARD_RST = 16'h0000;
  localparam logic [CNT_W-1:0] PERMIT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ALL_ONES = 16'hffff;
  localparam logic [CNT_W-1:0] ONE = 16'h0001;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [3:0] HALF_STRB = 4'h3;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_DELAYED = 2'h1,
    MODE_CONT = 2'h2,
    MODE_SPARE = 2'h3
  } opot_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LEG1 = 2'h1,
    ST_LEG2 = 2'h3
  } opot_state_t;

  typedef enum logic [2:0] {
    K_NONE = 3'h0,
    K_RUN = 3'h1,
    K_GUARD = 3'h2,
    K_PERMIT = 3'h3,
    K_COUNTER = 3'h4,
    K_RELOAD = 3'h5,
    K_MODE = 3'h6,
    K_CORR = 3'h7
  } opot_kind_t;

endpackage

// file: rtl/opot_top.sv
// top of the output pulse one-shot timer with its axi4-lite register slave
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
module opot_top #(
  parameter int NCH = opot_pkg::N_CH // channel count
) (
  input wire logic aclk, // system clock, 50 MHz
  input wire logic aresetn, // sync reset, active low
  input wire logic ce, // clock enable, freezes all state
  input wire logic count_tick, // prescaled count clock pulse
  input wire logic [NCH-1:0] ext_start, // external start requests
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [opot_pkg::ADDR_W-1:0] awaddr, // write address
  input wire logic [2:0] awprot, // write protection, unused
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  output logic [1:0] bresp, // write response
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  input wire logic [opot_pkg::ADDR_W-1:0] araddr, // read address
  input wire logic [2:0] arprot, // read protection, unused
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic [NCH-1:0] tout, // pulse outputs
  output logic [NCH-1:0] uflow_req // underflow request pulses
);
  import opot_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awrdy;
    logic wrdy;
    logic ardy;
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [NCH-1:0] run;
    logic [NCH-1:0] guard;
    logic [NCH-1:0] permit;
    logic [NCH-1:0][CNT_W-1:0] reload;
    logic [NCH-1:0][CNT_W-1:0] corr;
    opot_mode_t [NCH-1:0] mode;
  } opot_topst_t;

  typedef struct packed {
    opot_kind_t kind;
    logic [3:0] ch;
  } opot_dec_t;

  opot_topst_t s_q, s_d;
  opot_dec_t wdec, rdec;
  logic wr_fire, wr_ok;
  logic [NCH-1:0] ctr_we, corr_we, stop, uf;
  logic [NCH-1:0][CNT_W-1:0] cnt;
  logic [CNT_W-1:0] rval;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic opot_dec_t decode(input logic [ADDR_W-1:0] a);
    logic [IDX_W-1:0] idx;
    logic [IDX_W-1:0] off;
    opot_dec_t d;
    idx = a[ADDR_W-1:2];
    off = idx - CHAN_BASE_IDX;
    d.kind = K_NONE;
    d.ch = off[7:4];
    if (a[1:0] != 2'h0) begin
      d.kind = K_NONE;
    end else if (idx == RUN_IDX) begin
      d.kind = K_RUN;
    end else if (idx == GUARD_IDX) begin
      d.kind = K_GUARD;
    end else if (idx == PERMIT_IDX) begin
      d.kind = K_PERMIT;
    end else if (off[IDX_W-1:8] == '0 && 32'(off[7:4]) < NCH) begin
      case (off[3:0])
        SUB_COUNTER: d.kind = K_COUNTER;
        SUB_RELOAD: d.kind = K_RELOAD;
        SUB_MODE: d.kind = K_MODE;
        SUB_CORR: d.kind = K_CORR;
        default: d.kind = K_NONE;
      endcase
    end
    return d;
  endfunction

  // per-channel bits sit with channel n at data bit n, spare bits read 0
  function automatic logic [CNT_W-1:0] widen(input logic [NCH-1:0] v);
    logic [CNT_W-1:0] r;
    r = '0;
    r[NCH-1:0] = v;
    return r;
  endfunction

  assign wdec = decode(s_q.aw_addr);
  assign rdec = decode(araddr);
  assign wr_fire = ce && s_q.aw_have && s_q.w_have && !s_q.bvalid;
  // only whole halfword writes land; byte writes are answered but dropped
  assign wr_ok = wr_fire && wdec.kind != K_NONE && (s_q.w_strb & HALF_STRB) == HALF_STRB;

  // ----------------------------------------------------------------
  // register strobes to channels
  // ----------------------------------------------------------------
  always_comb begin
    ctr_we = '0;
    corr_we = '0;
    if (wr_ok && wdec.kind == K_COUNTER) begin
      ctr_we[wdec.ch] = 1'b1;
    end
    if (wr_ok && wdec.kind == K_CORR) begin
      corr_we[wdec.ch] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    case (rdec.kind)
      K_RUN: rval = widen(s_q.run);
      K_GUARD: rval = widen(s_q.guard);
      K_PERMIT: rval = widen(s_q.permit);
      K_COUNTER: rval = cnt[rdec.ch];
      K_RELOAD: rval = s_q.reload[rdec.ch];
      K_MODE: rval = {14'h0000, s_q.mode[rdec.ch]};
      K_CORR: rval = s_q.corr[rdec.ch];
      default: rval = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (ce) begin
      // write channel handshakes
      if (awvalid && s_q.awrdy) begin
        s_d.aw_have = 1'b1;
        s_d.aw_addr = awaddr;
      end
      if (wvalid && s_q.wrdy) begin
        s_d.w_have = 1'b1;
        s_d.w_data = wdata;
        s_d.w_strb = wstrb;
      end
      if (s_q.bvalid && bready) begin
        s_d.bvalid = 1'b0;
      end
      if (wr_fire) begin
        s_d.aw_have = 1'b0;
        s_d.w_have = 1'b0;
        s_d.bvalid = 1'b1;
        s_d.bresp = (wdec.kind == K_NONE) ? RESP_DECERR : RESP_OKAY;
      end
      if (wr_ok) begin
        case (wdec.kind)
          K_GUARD: s_d.guard = s_q.w_data[NCH-1:0];
          K_PERMIT: s_d.permit = s_q.w_data[NCH-1:0];
          K_RELOAD: s_d.reload[wdec.ch] = s_q.w_data[CNT_W-1:0];
          K_MODE: s_d.mode[wdec.ch] = opot_mode_t'(s_q.w_data[1:0]);
          K_CORR: s_d.corr[wdec.ch] = s_q.w_data[CNT_W-1:0];
          default: s_d.guard = s_q.guard;
        endcase
      end

      // run bits: software beats stop, stop beats external start
      for (int i = 0; i < NCH; i++) begin
        if (wr_ok && wdec.kind == K_RUN && !s_q.guard[i]) begin
          s_d.run[i] = s_q.w_data[i];
        end else if (stop[i]) begin
          s_d.run[i] = 1'b0;
        end else if (ext_start[i] && s_q.permit[i]) begin
          s_d.run[i] = 1'b1;
        end
      end

      // read channel
      if (s_q.rvalid && rready) begin
        s_d.rvalid = 1'b0;
      end
      if (arvalid && s_q.ardy) begin
        s_d.rvalid = 1'b1;
        s_d.rdata = {16'h0000, rval};
        s_d.rresp = (rdec.kind == K_NONE) ? RESP_DECERR : RESP_OKAY;
      end

      s_d.awrdy = !s_d.aw_have;
      s_d.wrdy = !s_d.w_have;
      s_d.ardy = !s_d.rvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.awrdy <= 1'b1;
      s_q.wrdy <= 1'b1;
      s_q.ardy <= 1'b1;
      s_q.run <= RUN_RST[NCH-1:0];
      s_q.guard <= GUARD_RST[NCH-1:0];
      s_q.permit <= PERMIT_RST[NCH-1:0];
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    opot_chan u_chan (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .tick(count_tick),
      .run(s_q.run[g]),
      .mode(s_q.mode[g]),
      .reload(s_q.reload[g]),
      .corr(s_q.corr[g]),
      .corr_we(corr_we[g]),
      .ctr_we(ctr_we[g]),
      .ctr_wd(s_q.w_data[CNT_W-1:0]),
      .cnt(cnt[g]),
      .tout(tout[g]),
      .uflow(uf[g]),
      .stop(stop[g])
    );
  end

  assign uflow_req = uf;
  assign awready = s_q.awrdy;
  assign wready = s_q.wrdy;
  assign arready = s_q.ardy;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;

endmodule

// file: tb/opot_checker.sv
// port assertions of the one-shot timer top
`timescale 1ns/1ps
module opot_checker #(
  parameter int NCH = opot_pkg::N_CH // channel count
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, active low
  input wire logic ce, // clock enable
  input wire logic count_tick, // count tick
  input wire logic awready, // aw ready
  input wire logic wready, // w ready
  input wire logic bvalid, // b valid
  input wire logic bready, // b ready
  input wire logic [1:0] bresp, // b response
  input wire logic arvalid, // ar valid
  input wire logic arready, // ar ready
  input wire logic rvalid, // r valid
  input wire logic [31:0] rdata, // read data
  input wire logic [NCH-1:0] tout, // pulse outputs
  input wire logic [NCH-1:0] uflow_req // underflow pulses
);
  import opot_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  chk_reset_idle: assert property (disable iff (1'h0)
    !aresetn |=> tout == '0 && uflow_req == '0 && !bvalid && !rvalid)
    else $error("outputs busy after reset");
  chk_uflow_tick: assert property (
    |uflow_req |-> $past(ce) && $past(count_tick))
    else $error("underflow without tick");
  chk_tout_tick: assert property (
    tout != $past(tout) |-> $past(ce) && $past(count_tick))
    else $error("output moved without tick");
  chk_uflow_toggle: assert property (
    (uflow_req & ~(tout ^ $past(tout))) == '0)
    else $error("underflow without toggle");
  chk_ce_freeze: assert property (
    !ce |=> $stable(tout) && $stable(uflow_req) && $stable(bvalid) && $stable(rvalid))
    else $error("state moved with ce low");
  chk_bresp_late: assert property (
    $rose(bvalid) |-> $past(awready) == 1'h0 && $past(wready) == 1'h0)
    else $error("response before both taken");
  chk_read_next: assert property (
    ce && arvalid && arready |=> rvalid)
    else $error("read answer late");
  chk_bresp_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("response dropped");
  chk_rdata_high: assert property (
    rvalid |-> rdata[31:16] == 16'h0000)
    else $error("upper read data set");
endmodule

// file: tb/output_pulse_oneshot_timer_bench.sv
// self-checking bench of the one-shot timer
`timescale 1ns/1ps
module output_pulse_oneshot_timer_bench;
  import opot_pkg::*;
  localparam int NCH = N_CH;
  localparam int TP = 4;
  logic aclk = 0, aresetn = 0, ce = 1, count_tick = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = '0;
  logic [1:0] bresp, rresp;
  logic [NCH-1:0] ext_start = '0, tout, uflow_req, tq = '0;
  logic [1:0] tdiv = '0;
  int n_errors = 0, checked = 0, cyc = 0;
  int uf[NCH], tg[NCH], wid[NCH], tl[NCH];
  always #10 aclk = ~aclk;
  opot_top #(.NCH(NCH)) dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .count_tick(count_tick),
    .ext_start(ext_start), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .tout(tout), .uflow_req(uflow_req));
  // ----------------------------------------
  // tick source and output monitor
  // ----------------------------------------
  always @(posedge aclk) begin
    tdiv <= tdiv + 2'h1;
    count_tick <= (tdiv == 2'h3);
  end
  always @(posedge aclk) begin
    cyc++;
    for (int i = 0; i < NCH; i++) begin
      if (uflow_req[i] === 1'h1) uf[i]++;
      if (tout[i] !== tq[i]) begin
        tg[i]++;
        wid[i] = cyc - tl[i];
        tl[i] = cyc;
      end
    end
    tq = tout;
  end
  task cmp_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task cmp_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task end_of_test;
    $display("mismatches %0d comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task timeout(input string nm);
    n_errors++;
    $display("CHECK FAILED %s expected answer seen timeout", nm);
    end_of_test;
  endtask
  function logic [IDX_W-1:0] cix(input int ch, input logic [3:0] sub);
    return CHAN_BASE_IDX + (IDX_W'(ch) << CHAN_STRIDE_SH) + IDX_W'(sub);
  endfunction
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task wr(input logic [IDX_W-1:0] ix, input logic [15:0] d, input logic [1:0] er);
    logic a, w;
    a = 0;
    w = 0;
    awaddr <= {ix, 2'h0};
    wdata <= {16'h0000, d};
    wstrb <= HALF_STRB;
    awvalid <= 1;
    wvalid <= 1;
    for (int n = 0; !(a && w); n++) begin
      @(posedge aclk);
      if (n > 100) timeout("write");
      if (awvalid && awready === 1'h1) begin
        a = 1;
        awvalid <= 0;
      end
      if (wvalid && wready === 1'h1) begin
        w = 1;
        wvalid <= 0;
      end
    end
    // late bready lets the response wait once
    repeat (2) @(posedge aclk);
    bready <= 1;
    for (int n = 0; n >= 0; n++) begin
      @(posedge aclk);
      if (bvalid === 1'h1) break;
      if (n > 100) timeout("bresp");
    end
    cmp_resp("bresp", er, bresp);
    bready <= 0;
  endtask
  task rd(input logic [IDX_W-1:0] ix, input logic [15:0] ev, input logic [1:0] er);
    araddr <= {ix, 2'h0};
    arvalid <= 1;
    rready <= 1;
    for (int n = 0; n >= 0; n++) begin
      @(posedge aclk);
      if (arvalid && arready === 1'h1) arvalid <= 0;
      if (rvalid === 1'h1) break;
      if (n > 100) timeout("read");
    end
    cmp_resp("rresp", er, rresp);
    if (er == RESP_OKAY) cmp_val("rdata", {16'h0000, ev}, rdata);
    rready <= 0;
  endtask
  task start(input int ch, input logic [15:0] md, input logic [15:0] p, input logic [15:0] rl);
    wr(cix(ch, SUB_MODE), md, RESP_OKAY);
    wr(cix(ch, SUB_COUNTER), p, RESP_OKAY);
    wr(cix(ch, SUB_RELOAD), rl, RESP_OKAY);
    uf[ch] = 0;
    tg[ch] = 0;
    wr(RUN_IDX, 16'h0001 << ch, RESP_OKAY);
  endtask
  task finish_ch(input int ch, input int nuf, input int w);
    for (int n = 0; uf[ch] < nuf; n++) begin
      @(posedge aclk);
      if (n > 2000) timeout("underflow");
    end
    repeat (4 * TP) @(posedge aclk);
    cmp_val("underflows", nuf, uf[ch]);
    cmp_val("toggles", 2, tg[ch]);
    if (w > 0) cmp_val("pulse width", w, wid[ch]);
    rd(RUN_IDX, 16'h0000, RESP_OKAY);
    rd(cix(ch, SUB_COUNTER), CNT_ALL_ONES, RESP_OKAY);
    $display("test of channel %0d done", ch);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(RUN_IDX, RUN_RST, RESP_OKAY);
    rd(GUARD_IDX, GUARD_RST, RESP_OKAY);
    rd(PERMIT_IDX, PERMIT_RST, RESP_OKAY);
    wr(GUARD_IDX, 16'hffff, RESP_OKAY);
    rd(GUARD_IDX, 16'h07ff, RESP_OKAY);
    wr(RUN_IDX, 16'hffff, RESP_OKAY);
    rd(RUN_IDX, 16'h0000, RESP_OKAY);
    wr(GUARD_IDX, 16'h0000, RESP_OKAY);
    rd(24'h80_02f8, 16'h0000, RESP_DECERR);
    $display("test of registers done");
    start(0, 16'(MODE_SINGLE), 16'h1234, 16'h0005);
    finish_ch(0, 1, 6 * TP);
    start(1, 16'(MODE_SINGLE), 16'h0000, 16'h0014);
    repeat (5 * TP) @(posedge aclk);
    wr(cix(1, SUB_CORR), 16'h0003, RESP_OKAY);
    finish_ch(1, 1, 25 * TP);
    start(2, 16'(MODE_SINGLE), 16'h0000, 16'hfff8);
    repeat (2 * TP) @(posedge aclk);
    wr(cix(2, SUB_CORR), 16'h0014, RESP_OKAY);
    finish_ch(2, 1, 0);
    start(3, 16'(MODE_DELAYED), 16'h0003, 16'h0004);
    finish_ch(3, 2, 5 * TP);
    wr(PERMIT_IDX, 16'h0010, RESP_OKAY);
    wr(cix(4, SUB_RELOAD), 16'h0003, RESP_OKAY);
    uf[4] = 0;
    tg[4] = 0;
    for (int n = 0; uflow_req[4] !== 1'h1; n++) begin
      @(posedge aclk);
      ext_start <= {NCH{count_tick}} & 11'h030;
      if (n > 400) timeout("external");
    end
    ext_start <= '0;
    finish_ch(4, 1, 4 * TP);
    cmp_val("unpermitted toggles", 0, tg[5]);
    start(6, 16'(MODE_DELAYED), 16'h0003, 16'h0010);
    for (int n = 0; uflow_req[6] !== 1'h1; n++) begin
      @(posedge aclk);
      if (n > 400) timeout("first underflow");
    end
    rd(cix(6, SUB_COUNTER), CNT_ALL_ONES, RESP_OKAY);
    repeat (2) @(posedge aclk);
    rd(cix(6, SUB_COUNTER), 16'h000f, RESP_OKAY);
    // two ticks lost while frozen stretch the pulse by eight cycles
    ce <= 0;
    repeat (8) @(posedge aclk);
    ce <= 1;
    finish_ch(6, 2, 17 * TP + 8);
    start(8, 16'(MODE_SINGLE), 16'h0000, 16'h0003);
    for (int n = 0; tout[8] !== 1'h1; n++) begin
      @(posedge aclk);
      if (n > 400) timeout("start");
    end
    // run write lands on the edge where the stop pulse arrives
    repeat (14) @(posedge aclk);
    wr(RUN_IDX, 16'h0100, RESP_OKAY);
    uf[8] = 0;
    tg[8] = 0;
    rd(RUN_IDX, 16'h0100, RESP_OKAY);
    finish_ch(8, 1, 4 * TP);
    start(9, 16'(MODE_CONT), 16'h0001, 16'h0002);
    for (int n = 0; uf[9] < 2; n++) begin
      @(posedge aclk);
      if (n > 400) timeout("continuous");
    end
    rd(RUN_IDX, 16'h0200, RESP_OKAY);
    wr(PERMIT_IDX, 16'h0200, RESP_OKAY);
    fork
      wr(RUN_IDX, 16'h0000, RESP_OKAY);
      begin
        @(posedge aclk);
        ext_start <= 11'h200;
        @(posedge aclk);
        ext_start <= '0;
      end
    join
    uf[9] = 0;
    repeat (8 * TP) @(posedge aclk);
    cmp_val("stopped underflows", 0, uf[9]);
    rd(RUN_IDX, 16'h0000, RESP_OKAY);
    $display("test of channel 9 done");
    end_of_test;
  end
endmodule
bind opot_top opot_checker #(.NCH(NCH)) u_chk (.aclk(aclk), .aresetn(aresetn), .ce(ce),
  .count_tick(count_tick), .awready(awready), .wready(wready), .bvalid(bvalid),
  .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .rdata(rdata), .tout(tout), .uflow_req(uflow_req));
